// >>> src/sltc_regs.svh
// Register offsets, reset values, field positions and frame counts
`ifndef SLTC_REGS_SVH
`define SLTC_REGS_SVH
`define SLTC_ADDR_LANE_EN 16'h8086
`define SLTC_ADDR_PLL 16'h8087
`define SLTC_ADDR_SYNC 16'h8088
`define SLTC_ADDR_TFAIL 16'h8089
`define SLTC_ADDR_TEST 16'h808A
`define SLTC_RST_LANE_EN 16'hFFFF
`define SLTC_RST_PLL 16'h8000
`define SLTC_RST_SYNC 16'h0000
`define SLTC_RST_TFAIL 16'h8000
`define SLTC_RST_TEST 16'h0000
`define SLTC_BIT_PLL_EN 15
`define SLTC_BIT_TFAIL_SEL 15
`define SLTC_TEST_WMASK 16'h3FFF
`define SLTC_PREAMBLE_LEN 6'h20
`define SLTC_HDR_LAST 6'h0C
`define SLTC_DATA_LAST 6'h0F
`define SLTC_DEVAD_A 5'h04
`define SLTC_DEVAD_B 5'h05
`define SLTC_SIDE_LANES 4
`define SLTC_PPM_521 11'h209
`define SLTC_PPM_390 11'h186
`define SLTC_PPM_195 11'h0C3
`define SLTC_PPM_98 11'h062
`define SLTC_PPM_695 11'h2B7
`endif

// >>> src/sltc_pkg.sv
// Types shared by the lane and test control register bank
`default_nettype none
package sltc_pkg;
  typedef enum logic [1:0] {
    SLTC_PRE = 2'b00,
    SLTC_HDR = 2'b01,
    SLTC_TA = 2'b10,
    SLTC_DATA = 2'b11
  } sltc_state_t;

  typedef enum logic [1:0] {
    SLTC_OP_ADDR = 2'b00,
    SLTC_OP_WRITE = 2'b01,
    SLTC_OP_RDINC = 2'b10,
    SLTC_OP_READ = 2'b11
  } sltc_op_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic [1:0] equalizer_probe_mode;
    logic pad_loop_return;
    logic int_loop;
    logic scan_input_enable;
    logic scan_output_enable;
    logic [3:0] frequency_ramp_select;
    logic pll_bypass_select;
    logic [2:0] pattern_select;
  } sltc_test_word_t;

  typedef struct packed {
    logic [7:0] tx;
    logic [7:0] rx;
  } sltc_lanes_t;

  typedef struct packed {
    logic [1:0] equalizer_probe_mode;
    logic pad_loop_return;
    logic int_loop;
    logic rx_scan_input_enable;
    logic tx_scan_output_enable;
    logic pll_bypass_select;
    logic [2:0] pattern_select;
  } sltc_test_ctl_t;
endpackage : sltc_pkg

`default_nettype wire

// >>> src/sltc_top.sv
// Lane pair, PLL and test control registers behind a Clause 45 MDIO slave
// Overview of operation
// - Transmit pair of lane n follows lane-enable bit 8+n; bit 15 is lane 7.
// - Receive pair of lane n follows lane-enable bit n; bit 7 is lane 7.
// - Whole-device power-down turns off every transmit and receive pair.
// - Side A power-down kills lanes 0-3, side B kills lanes 4-7.
// - Tx bits 11:8, rx bits 3:0 are side A; 15:12 and 7:4 side B.
// - PLL control bit 15 runs the serializer PLL; enabled after reset.
// - Lane status bits 15:8 are unsupported comma flags, read zero.
// - Lane status bits 7:0 are unsupported link-lost flags, read zero.
// - Test-fail pin shows transmit failure on select zero, receive on one.
// - Test bits 13:12 pick equalizer probe mode; zero after reset.
// - Pad loopback acts only while internal loopback bit 10 is set.
// - Test bit 10 enables internal loopback for pattern checking.
// - Test bit 9 enables scan inputs on the receive serializer only.
// - Test bit 8 enables scan outputs on the transmit serializer only.
// - Test bit 3 bypasses the serializer PLL; zero after reset.
// - Test bits 2:0 select generated and checked test pattern.
// - Test bits 7:4 select frequency ramp; off whenever bit 4 is zero.
// - Ramp codes map to fixed ppm offsets; top two depend on quick update.
// - The quick update enable input modifies the two highest ramp codes.
`timescale 1ns/1ns
`default_nettype none
`include "sltc_regs.svh"

module sltc_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic [4:0] port_addr,
  input wire logic pd_all,
  input wire logic pd_side_a,
  input wire logic pd_side_b,
  input wire logic quick_update_enable,
  input wire logic tx_test_fail,
  input wire logic rx_test_fail,
  output var sltc_pkg::sltc_lanes_t pair_en,
  output logic pll_enable,
  output logic test_fail_out,
  output var sltc_pkg::sltc_test_ctl_t test_ctl,
  output logic ramp_enable,
  output logic signed [10:0] ramp_ppm
);
  import sltc_pkg::*;

  // Management pins are asynchronous to clk
  logic mdc_s1, mdc_s2, mdc_s3;
  logic mdio_s1, mdio_s2;
  logic [4:0] prt_s1, prt_s2;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_s3 <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
      prt_s1 <= 5'h00;
      prt_s2 <= 5'h00;
    end else begin
      mdc_s1 <= mdc;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= mdio_i;
      mdio_s2 <= mdio_s1;
      prt_s1 <= port_addr;
      prt_s2 <= prt_s1;
    end
  end

  logic mdc_rise, mdc_fall;
  assign mdc_rise = mdc_s2 & ~mdc_s3;
  assign mdc_fall = ~mdc_s2 & mdc_s3;

  sltc_state_t state_r;
  logic [5:0] cnt_r;
  logic [15:0] shift_r;
  sltc_op_t op_r;
  logic hit_r;
  logic [12:0] hdr;
  logic [15:0] word;
  logic frame_end;

  assign hdr = {shift_r[11:0], mdio_s2};
  assign word = {shift_r[14:0], mdio_s2};
  assign frame_end = (state_r == SLTC_DATA) && mdc_rise &&
                     (cnt_r == `SLTC_DATA_LAST);

  // Frame walker: preamble, ST/OP/PRTAD/DEVAD, turnaround, data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= SLTC_PRE;
      cnt_r <= 6'h00;
      shift_r <= 16'h0000;
      op_r <= SLTC_OP_ADDR;
      hit_r <= 1'b0;
    end else if (mdc_rise) begin
      case (state_r)
        SLTC_PRE: begin
          if (mdio_s2) begin
            if (cnt_r != `SLTC_PREAMBLE_LEN) begin
              cnt_r <= cnt_r + 6'h01;
            end
          end else if (cnt_r == `SLTC_PREAMBLE_LEN) begin
            state_r <= SLTC_HDR;
            cnt_r <= 6'h00;
          end else begin
            cnt_r <= 6'h00;
          end
        end
        SLTC_HDR: begin
          shift_r <= word;
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == `SLTC_HDR_LAST) begin
            cnt_r <= 6'h00;
            // A second start bit of one is not a Clause 45 frame
            if (hdr[12]) begin
              state_r <= SLTC_PRE;
            end else begin
              state_r <= SLTC_TA;
              op_r <= sltc_op_t'(hdr[11:10]);
              hit_r <= (hdr[9:5] == prt_s2) &&
                       ((hdr[4:0] == `SLTC_DEVAD_A) ||
                        (hdr[4:0] == `SLTC_DEVAD_B));
            end
          end
        end
        SLTC_TA: begin
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'h01) begin
            state_r <= SLTC_DATA;
            cnt_r <= 6'h00;
          end
        end
        SLTC_DATA: begin
          shift_r <= word;
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == `SLTC_DATA_LAST) begin
            state_r <= SLTC_PRE;
            cnt_r <= 6'h00;
          end
        end
        default: begin
          state_r <= SLTC_PRE;
          cnt_r <= 6'h00;
        end
      endcase
    end
  end

  logic [15:0] addr_r;
  logic [15:0] lane_en_r;
  logic [15:0] pll_r;
  logic [15:0] tfail_r;
  sltc_test_word_t test_r;
  logic is_rd;
  logic hit_end;
  assign is_rd = op_r[1];
  assign hit_end = frame_end && hit_r;

  // One address pointer serves both device addresses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_r <= 16'h0000;
    end else if (hit_end) begin
      if (op_r == SLTC_OP_ADDR) begin
        addr_r <= word;
      end else if (op_r == SLTC_OP_RDINC) begin
        addr_r <= addr_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lane_en_r <= `SLTC_RST_LANE_EN;
      pll_r <= `SLTC_RST_PLL;
      tfail_r <= `SLTC_RST_TFAIL;
      test_r <= `SLTC_RST_TEST;
    end else if (hit_end && (op_r == SLTC_OP_WRITE)) begin
      case (addr_r)
        `SLTC_ADDR_LANE_EN: lane_en_r <= word;
        `SLTC_ADDR_PLL: pll_r <= word & `SLTC_RST_PLL;
        `SLTC_ADDR_TFAIL: tfail_r <= word & `SLTC_RST_TFAIL;
        `SLTC_ADDR_TEST: test_r <= word & `SLTC_TEST_WMASK;
        default: ;
      endcase
    end
  end

  // Unmapped addresses and the unsupported status word read zero
  function automatic logic [15:0] rd_value(input logic [15:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      `SLTC_ADDR_LANE_EN: v = lane_en_r;
      `SLTC_ADDR_PLL: v = pll_r;
      `SLTC_ADDR_SYNC: v = `SLTC_RST_SYNC;
      `SLTC_ADDR_TFAIL: v = tfail_r;
      `SLTC_ADDR_TEST: v = test_r;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : rd_value

  // Read driver changes on falling MDC so the station samples on rising
  logic [15:0] rd_shift_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
      rd_shift_r <= 16'h0000;
    end else if (mdc_rise && (state_r == SLTC_TA) && (cnt_r == 6'h01)) begin
      rd_shift_r <= rd_value(addr_r);
    end else if (mdc_fall) begin
      if (hit_r && is_rd && (state_r == SLTC_TA) && (cnt_r == 6'h01)) begin
        mdio_o <= 1'b0;
        mdio_oe <= 1'b1;
      end else if (hit_r && is_rd && (state_r == SLTC_DATA)) begin
        mdio_o <= rd_shift_r[15];
        mdio_oe <= 1'b1;
        rd_shift_r <= {rd_shift_r[14:0], 1'b0};
      end else begin
        mdio_o <= 1'b0;
        mdio_oe <= 1'b0;
      end
    end
  end

  // Lane pair gating, power-down always wins over the enable bits
  logic [7:0] lane_off;
  logic [7:0] tx_nxt, rx_nxt;
  for (genvar n = 0; n < 8; n++) begin : g_lane
    if (n < `SLTC_SIDE_LANES) begin : g_side_a
      assign lane_off[n] = pd_all | pd_side_a;
    end else begin : g_side_b
      assign lane_off[n] = pd_all | pd_side_b;
    end
    assign tx_nxt[n] = lane_en_r[8 + n] & ~lane_off[n];
    assign rx_nxt[n] = lane_en_r[n] & ~lane_off[n];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pair_en <= '0;
    end else begin
      pair_en.tx <= tx_nxt;
      pair_en.rx <= rx_nxt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pll_enable <= 1'b1;
      test_fail_out <= 1'b0;
    end else begin
      pll_enable <= pll_r[`SLTC_BIT_PLL_EN];
      test_fail_out <= tfail_r[`SLTC_BIT_TFAIL_SEL] ? rx_test_fail
                                                    : tx_test_fail;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      test_ctl <= '0;
    end else begin
      test_ctl.equalizer_probe_mode <= test_r.equalizer_probe_mode;
      test_ctl.pad_loop_return <= test_r.pad_loop_return &
                                  test_r.int_loop;
      test_ctl.int_loop <= test_r.int_loop;
      test_ctl.rx_scan_input_enable <= test_r.scan_input_enable;
      test_ctl.tx_scan_output_enable <= test_r.scan_output_enable;
      test_ctl.pll_bypass_select <= test_r.pll_bypass_select;
      // Reserved codes are passed on; the pattern engine treats them as off
      test_ctl.pattern_select <= test_r.pattern_select;
    end
  end

  function automatic logic signed [10:0] ramp_value(input logic [3:0] c,
                                                    input logic q);
    logic signed [10:0] p;
    p = 11'h000;
    case (c[3:1])
      3'h0: p = -`SLTC_PPM_521;
      3'h1: p = `SLTC_PPM_521;
      3'h2: p = -`SLTC_PPM_390;
      3'h3: p = `SLTC_PPM_390;
      3'h4: p = -`SLTC_PPM_195;
      3'h5: p = `SLTC_PPM_195;
      3'h6: p = q ? -`SLTC_PPM_695 : -`SLTC_PPM_98;
      3'h7: p = q ? `SLTC_PPM_695 : `SLTC_PPM_98;
      default: p = 11'h000;
    endcase
    return p;
  endfunction : ramp_value

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ramp_enable <= 1'b0;
      ramp_ppm <= 11'h000;
    end else if (test_r.frequency_ramp_select[0]) begin
      ramp_enable <= 1'b1;
      ramp_ppm <= ramp_value(test_r.frequency_ramp_select,
                             quick_update_enable);
    end else begin
      ramp_enable <= 1'b0;
      ramp_ppm <= 11'h000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_all_power_down: assert property (
    pd_all |=> (pair_en == '0))
    else $error("pairs still enabled under full power-down");
  a_side_a_down: assert property (
    pd_side_a |=> (pair_en.tx[3:0] == 4'h0) && (pair_en.rx[3:0] == 4'h0))
    else $error("side A lanes enabled while side A powered down");
  a_side_b_down: assert property (
    pd_side_b |=> (pair_en.tx[7:4] == 4'h0) && (pair_en.rx[7:4] == 4'h0))
    else $error("side B lanes enabled while side B powered down");
  a_tx_lane_map: assert property (
    arst_n && !pd_all && !pd_side_a && !pd_side_b |=>
      pair_en.tx == $past(lane_en_r[15:8]))
    else $error("transmit pair enables do not follow bits 15:8");
  a_rx_lane_map: assert property (
    arst_n && !pd_all && !pd_side_a && !pd_side_b |=>
      pair_en.rx == $past(lane_en_r[7:0]))
    else $error("receive pair enables do not follow bits 7:0");
  a_pll_write: assert property (
    hit_end && (op_r == SLTC_OP_WRITE) && (addr_r == `SLTC_ADDR_PLL) |=>
      ##1 (pll_enable == $past(word[`SLTC_BIT_PLL_EN], 2)))
    else $error("PLL enable does not follow written bit");
  a_fail_route: assert property (
    arst_n |=> test_fail_out == ($past(tfail_r[15]) ? $past(rx_test_fail)
                                             : $past(tx_test_fail)))
    else $error("test fail pin routes wrong source");
  a_pad_needs_loop: assert property (
    test_ctl.pad_loop_return |-> test_ctl.int_loop)
    else $error("pad loopback active without internal loopback");
  a_test_rsv_zero: assert property (
    test_r.rsv == 2'b00)
    else $error("reserved test bits not zero");
  a_ramp_off: assert property (
    !test_r.frequency_ramp_select[0] |=> !ramp_enable && (ramp_ppm == 11'h000))
    else $error("ramp active with bit four clear");
  a_fast_ramp: assert property (
    (test_r.frequency_ramp_select == 4'hF) && quick_update_enable |=>
      ramp_ppm == `SLTC_PPM_695)
    else $error("fast top ramp code not +695 ppm");
  a_read_drive: assert property (
    mdc_fall && hit_r && is_rd && (state_r == SLTC_DATA) |=> mdio_oe)
    else $error("read data not driven");

  c_lane_write: cover property (
    hit_end && (op_r == SLTC_OP_WRITE) && (addr_r == `SLTC_ADDR_LANE_EN));
  c_read_frame: cover property (hit_end && is_rd);
  c_side_a_down: cover property (pd_side_a && !pd_all);
  c_fast_ramp: cover property (ramp_enable && quick_update_enable);
endmodule : sltc_top

`default_nettype wire

// >>> tb/sltc_station.sv
// Management station model that drives Clause 45 frames on MDC and MDIO
`timescale 1ns/1ns
`default_nettype none

module sltc_station (
  input wire logic clk,
  input wire logic mdio_in,
  output logic mdc,
  output logic mdio_o,
  output logic mdio_oe
);
  initial begin
    mdc = 1'b0;
    mdio_o = 1'b0;
    mdio_oe = 1'b0;
  end

  // Ten clocks per MDC period, so each phase spans five clocks
  task automatic put(input logic b, input logic drv, output logic seen);
    @(posedge clk);
    mdc <= 1'b0;
    mdio_o <= b;
    mdio_oe <= drv;
    repeat (5) @(posedge clk);
    seen = mdio_in;
    mdc <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : put

  // Read ops release the line from turnaround on; MDC idles low after
  task automatic frame(input logic [1:0] op, input logic [4:0] prt,
      input logic [4:0] dev, input logic [15:0] wd,
      output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b00, op, prt, dev};
    repeat (32) put(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) put(hdr[i], 1'b1, s);
    put(1'b1, !op[1], s);
    put(1'b0, !op[1], s);
    for (int i = 15; i >= 0; i--) begin
      put(wd[i], !op[1], s);
      rd[i] = s;
    end
    @(posedge clk);
    mdc <= 1'b0;
    mdio_oe <= 1'b0;
  endtask : frame
endmodule : sltc_station

`default_nettype wire

// >>> tb/tb_serdes_lane_test_control_regs.sv
// Self-checking bench for the lane and test control register bank
`timescale 1ns/1ns
`default_nettype none

module tb_serdes_lane_test_control_regs;
  import sltc_pkg::*;
  localparam logic [4:0] PRT = 5'h0B;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic pd_all = 1'b0;
  logic pd_side_a = 1'b0;
  logic pd_side_b = 1'b0;
  logic qu = 1'b0;
  logic tx_tf = 1'b0;
  logic rx_tf = 1'b0;
  logic mdc, st_o, st_oe, mdio_o, mdio_oe, pll_enable, test_fail_out;
  logic ramp_enable;
  logic signed [10:0] ramp_ppm;
  sltc_lanes_t pair_en;
  sltc_test_ctl_t test_ctl;
  wire logic mdio_w;
  logic [15:0] ptr = 16'hFFFF;
  logic [15:0] rv [5] = '{16'hFFFF, 16'h8000, 16'h0000, 16'h8000, 16'h0000};
  logic [15:0] tw [5] = '{16'h0800, 16'h0400, 16'h0200, 16'h0100, 16'h0008};
  logic [15:0] tc [5] = '{16'h0000, 16'h0040, 16'h0020, 16'h0010, 16'h0008};
  int mag [8] = '{521, 521, 390, 390, 195, 195, 98, 98};
  int miscompares = 0;
  int n_tests = 0;

  // MDIO carries a pull-up, so an undriven line reads one
  assign mdio_w = mdio_oe ? mdio_o : (st_oe ? st_o : 1'b1);

  always #20 clk = ~clk;

  sltc_station st (.clk(clk), .mdio_in(mdio_w), .mdc(mdc), .mdio_o(st_o),
    .mdio_oe(st_oe));

  sltc_top uut (.clk(clk), .arst_n(arst_n), .mdc(mdc), .mdio_i(mdio_w),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .port_addr(PRT), .pd_all(pd_all),
    .pd_side_a(pd_side_a), .pd_side_b(pd_side_b),
    .quick_update_enable(qu), .tx_test_fail(tx_tf), .rx_test_fail(rx_tf),
    .pair_en(pair_en), .pll_enable(pll_enable),
    .test_fail_out(test_fail_out), .test_ctl(test_ctl),
    .ramp_enable(ramp_enable), .ramp_ppm(ramp_ppm));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // Address frames only when the pointer moves, to keep the run short
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] x;
    if (a !== ptr) st.frame(2'b00, PRT, 5'h04, a, x);
    ptr = a;
    st.frame(2'b01, PRT, 5'h05, d, x);
    repeat (3) @(posedge clk);
  endtask : wr

  task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    if (a !== ptr) st.frame(2'b00, PRT, 5'h05, a, d);
    ptr = a;
    st.frame(2'b11, PRT, 5'h04, 16'h0000, d);
    check(d, e);
  endtask : rdchk

  task automatic pwr(input logic [2:0] p, input logic [15:0] e);
    @(posedge clk);
    {pd_all, pd_side_a, pd_side_b} <= p;
    repeat (3) @(posedge clk);
    check(pair_en, e);
  endtask : pwr

  function automatic logic [10:0] ppm(input logic [3:0] c, input logic q);
    int m;
    m = (c[3:2] == 2'b11 && q) ? 695 : mag[c[3:1]];
    if (!c[0])
      m = 0;
    return 11'(c[1] ? m : -m);
  endfunction : ppm

  initial begin
    logic [15:0] d;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(pair_en, 16'hFFFF);
    check({15'h0000, pll_enable}, 16'h0001);
    check({6'h00, test_ctl}, 16'h0000);
    for (int i = 0; i < 5; i++) rdchk(16'h8086 + 16'(i), rv[i]);
    wr(16'h8086, 16'hA5C3);
    check(pair_en, 16'hA5C3);
    pwr(3'b010, 16'hA0C0);
    pwr(3'b001, 16'h0503);
    pwr(3'b100, 16'h0000);
    pwr(3'b000, 16'hA5C3);
    rdchk(16'h8086, 16'hA5C3);
    // Side B acts as primary here, so side A enables may be cleared
    wr(16'h8086, 16'hF0F0);
    check(pair_en, 16'hF0F0);
    wr(16'h8087, 16'h7FFF);
    check({15'h0000, pll_enable}, 16'h0000);
    rdchk(16'h8087, 16'h0000);
    wr(16'h8087, 16'hFFFF);
    check({15'h0000, pll_enable}, 16'h0001);
    rdchk(16'h8087, 16'h8000);
    for (int s = 0; s < 2; s++) begin
      wr(16'h8089, {s[0], 15'h0000});
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        {tx_tf, rx_tf} <= k[1:0];
        repeat (3) @(posedge clk);
        check({15'h0000, test_fail_out},
              {15'h0000, s[0] ? k[0] : k[1]});
      end
    end
    wr(16'h808A, 16'hFFFF);
    check({6'h00, test_ctl}, 16'h03FF);
    rdchk(16'h808A, 16'h3FFF);
    for (int i = 0; i < 5; i++) begin
      wr(16'h808A, tw[i]);
      check({6'h00, test_ctl}, tc[i]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(16'h808A, {2'b00, i[1:0], 9'h000, i[2:0]});
      check({6'h00, test_ctl}, {6'h00, i[1:0], 5'h00, i[2:0]});
    end
    for (int c = 0; c < 16; c++) begin
      wr(16'h808A, {8'h00, c[3:0], 4'h0});
      for (int q = 0; q < 2; q++) begin
        @(posedge clk);
        qu <= q[0];
        repeat (3) @(posedge clk);
        check({15'h0000, ramp_enable}, {15'h0000, c[0]});
        check({5'h00, ramp_ppm}, {5'h00, ppm(c[3:0], q[0])});
      end
    end
    // Frames for a foreign device or port address must leave the bank alone
    st.frame(2'b00, PRT, 5'h03, 16'h8087, d);
    st.frame(2'b01, PRT, 5'h03, 16'h0000, d);
    st.frame(2'b00, PRT ^ 5'h01, 5'h04, 16'h8087, d);
    st.frame(2'b01, PRT ^ 5'h01, 5'h04, 16'h0000, d);
    repeat (3) @(posedge clk);
    check({15'h0000, pll_enable}, 16'h0001);
    wr(16'h8088, 16'hFFFF);
    rdchk(16'h8088, 16'h0000);
    rdchk(16'h8090, 16'h0000);
    st.frame(2'b00, PRT, 5'h04, 16'h8086, d);
    st.frame(2'b10, PRT, 5'h04, 16'h0000, d);
    check(d, 16'hF0F0);
    st.frame(2'b11, PRT, 5'h05, 16'h0000, d);
    check(d, 16'h8000);
    complete_run();
  end

  initial begin
    repeat (95000) @(posedge clk);
    miscompares++;
    complete_run();
  end
endmodule : tb_serdes_lane_test_control_regs

`default_nettype wire
